// ---- hw/bsrs_pkg.sv ----
// package: constants and types for the boundary-scan register set
// assumes: an outside tap state machine drives one-hot state strobes
package bsrs_pkg;

    localparam int IR_WIDTH = 8;
    localparam int BSR_WIDTH = 18;
    localparam int BCR_WIDTH = 2;
    localparam logic [7:0] IR_CAPTURE_VALUE = 8'h81;
    localparam logic [7:0] IR_RESET_VALUE = 8'hFF;
    localparam logic [1:0] BCR_RESET_VALUE = 2'h2;
    localparam int CELL_LATCH_ENABLE = 17;
    localparam int CELL_OUTPUT_ENABLE = 16;
    localparam int CELL_DATA_IN_TOP = 15;
    localparam int CELL_DATA_IN_BOT = 8;
    localparam int CELL_LATCH_OUT_TOP = 7;
    localparam int CELL_LATCH_OUT_BOT = 0;
    localparam int SYNC_STAGES = 2;

    // opcode with bit 7 dropped
    localparam logic [6:0] OP_EXTEST_A = 7'h00;
    localparam logic [6:0] OP_BYPASS_A = 7'h01;
    localparam logic [6:0] OP_SAMPLE = 7'h02;
    localparam logic [6:0] OP_EXTEST_B = 7'h03;
    localparam logic [6:0] OP_BYPASS_B = 7'h04;
    localparam logic [6:0] OP_BYPASS_C = 7'h05;
    localparam logic [6:0] OP_FLOAT = 7'h06;
    localparam logic [6:0] OP_HOLD = 7'h07;
    localparam logic [6:0] OP_BYPASS_D = 7'h08;
    localparam logic [6:0] OP_RUN_TEST = 7'h09;
    localparam logic [6:0] OP_READ_NORMAL = 7'h0A;
    localparam logic [6:0] OP_READ_TEST = 7'h0B;
    localparam logic [6:0] OP_SELF_TEST = 7'h0C;
    localparam logic [6:0] OP_TOGGLE = 7'h0D;
    localparam logic [6:0] OP_CTRL_NORMAL = 7'h0E;
    localparam logic [6:0] OP_CTRL_TEST = 7'h0F;

    typedef enum logic [1:0] {
        BSRS_SEL_BYPASS = 2'h0,
        BSRS_SEL_CELLS = 2'h1,
        BSRS_SEL_CTRL = 2'h2
    } bsrs_sel_type;

    typedef enum logic [1:0] {
        BSRS_MODE_NORMAL = 2'h0,
        BSRS_MODE_TEST = 2'h1,
        BSRS_MODE_FLOAT = 2'h2
    } bsrs_mode_type;

    typedef enum logic [1:0] {
        BSRS_CAP_PINS = 2'h0,
        BSRS_CAP_HOLD = 2'h1,
        BSRS_CAP_INVERT = 2'h2
    } bsrs_cap_type;

    // run-test operations held in the boundary-control register
    typedef enum logic [1:0] {
        BSRS_RT_SAMPLE_TOGGLE = 2'h0,
        BSRS_RT_PATTERN = 2'h1,
        BSRS_RT_SIGNATURE = 2'h2,
        BSRS_RT_BOTH = 2'h3
    } bsrs_runop_type;

    typedef struct packed {
        bsrs_sel_type sel;
        bsrs_mode_type mode;
        bsrs_cap_type cap;
    } bsrs_decode_type;

    // one-hot tap state strobes from the controller
    typedef struct packed {
        logic testReset;
        logic captureIr;
        logic shiftIr;
        logic updateIr;
        logic captureDr;
        logic shiftDr;
        logic updateDr;
    } bsrs_tap_type;

    typedef struct packed {
        logic latchEnable;
        logic outputEnable_b;
        logic [7:0] dataIn;
    } bsrs_pins_type;

    typedef struct packed {
        logic [IR_WIDTH-1:0] irShift;
        logic [BSR_WIDTH-1:0] bsrShift;
        logic [BCR_WIDTH-1:0] bcrShift;
        logic bypass;
        logic [1:0] tdiSync;
    } bsrs_rise_type;

    typedef struct packed {
        logic [IR_WIDTH-1:0] irShadow;
        logic [BSR_WIDTH-1:0] bsrShadow;
        logic [BCR_WIDTH-1:0] bcrShadow;
        logic tdo;
        logic tdoEn;
    } bsrs_fall_type;

    // maps a shadowed instruction to its register, mode and capture source
    function automatic bsrs_decode_type bsrs_decode(
        input logic [IR_WIDTH-1:0] ir
    );
        bsrs_decode_type d;
        d = '{BSRS_SEL_BYPASS, BSRS_MODE_NORMAL, BSRS_CAP_PINS};
        unique case (ir[6:0])
            OP_EXTEST_A, OP_EXTEST_B:
                d = '{BSRS_SEL_CELLS, BSRS_MODE_TEST, BSRS_CAP_PINS};
            OP_SAMPLE:
                d = '{BSRS_SEL_CELLS, BSRS_MODE_NORMAL, BSRS_CAP_PINS};
            OP_FLOAT:
                d = '{BSRS_SEL_BYPASS, BSRS_MODE_FLOAT, BSRS_CAP_PINS};
            OP_HOLD, OP_RUN_TEST, OP_TOGGLE:
                d = '{BSRS_SEL_BYPASS, BSRS_MODE_TEST, BSRS_CAP_PINS};
            OP_READ_NORMAL:
                d = '{BSRS_SEL_CELLS, BSRS_MODE_NORMAL, BSRS_CAP_HOLD};
            OP_READ_TEST:
                d = '{BSRS_SEL_CELLS, BSRS_MODE_TEST, BSRS_CAP_HOLD};
            OP_SELF_TEST:
                d = '{BSRS_SEL_CELLS, BSRS_MODE_NORMAL, BSRS_CAP_INVERT};
            OP_CTRL_NORMAL:
                d = '{BSRS_SEL_CTRL, BSRS_MODE_NORMAL, BSRS_CAP_HOLD};
            OP_CTRL_TEST:
                d = '{BSRS_SEL_CTRL, BSRS_MODE_TEST, BSRS_CAP_HOLD};
            default:
                d = '{BSRS_SEL_BYPASS, BSRS_MODE_NORMAL, BSRS_CAP_PINS};
        endcase
        return d;
    endfunction

endpackage

// ---- hw/bsrs_register_set.sv ----
// boundary-scan instruction register, decoder and test data registers
// assumes: tap strobes are sampled on the test clock rising edge; the
// rising-edge state and falling-edge state live in one test clock domain;
// pins arrive asynchronously and are synchronised on the test clock
//
// Behaviour
// R1 - eight-bit instruction, bit 7 ignored in decode
// R2 - no parity check, every opcode accepted
// R3 - capture-ir loads 10000001 for shifting out
// R4 - update-ir moves instruction into shadow latches
// R5 - power-up and reset force instruction 11111111
// R6 - unknown opcodes run as bypass, normal
// R7 - instruction picks mode, register, capture source
// R8 - 00/03 boundary test, 02 sample, bypass codes
// R9 - 06 float, 07 hold, 09 run, 0A/0B read
// R10 - 0C self-test, 0D toggle, 0E/0F control scan
// R11 - boundary chain has eighteen cells
// R12 - chain shifts tdi through 17 to 0
// R13 - cells: 17 le, 16 oe, data, outputs
// R14 - chain unchanged in reset, instruction controls capture
// R15 - control register resets to 10
// R16 - control register holds during data capture
// R17 - bypass cell captures zero
// R18 - boundary scan captures pins, drives from cells
// R19 - sample captures pins, leaves normal mode
// R20 - bypass: one bit, capture zero, normal
// R21 - shadows load on falling edge after update
// R22 - control codes: toggle, pattern, signature, both
// R23 - tdi sampled rising, tdo changes falling
// R24 - ir and control shift lsb first
// R25 - controller scans full instruction before use
`timescale 1ns/1ps
`default_nettype none

module bsrs_register_set
    import bsrs_pkg::*;
#(
    parameter int CELLS = BSR_WIDTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tck,
    input wire logic tdi,
    input wire bsrs_tap_type tap,
    input wire bsrs_pins_type pinsIn,
    input wire logic [7:0] coreOut,
    output logic tdo,
    output logic tdoEn,
    output logic testMode,
    output logic floatOutputs,
    output logic [CELLS-1:0] cellDrive,
    output bsrs_runop_type runOp,
    output logic [IR_WIDTH-1:0] instruction
);

    // ************************************************************
    // parameter check
    // ************************************************************
    if (CELLS != BSR_WIDTH) begin : g_bad_cells
        $error("cell count must match the pin map");
    end

    // ************************************************************
    // clock crossings: pins brought into the test clock domain, mode flag into clk
    // ************************************************************
    logic [9:0] pinSync1_r;
    logic [9:0] pinSync2_r;
    logic [7:0] coreSync1_r;
    logic [7:0] coreSync2_r;

    always_ff @(posedge tck) begin
        pinSync1_r <= pinsIn;
        pinSync2_r <= pinSync1_r;
        coreSync1_r <= coreOut;
        coreSync2_r <= coreSync1_r;
    end

    // clk domain only holds a registered copy of the mode flag
    logic testModeClk1_r;
    logic testModeClk_r;
    logic testModeRaw;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            testModeClk1_r <= 1'b0;
            testModeClk_r <= 1'b0;
        end else begin
            testModeClk1_r <= testModeRaw;
            testModeClk_r <= testModeClk1_r;
        end
    end

    // ************************************************************
    // rising edge: capture and shift
    // ************************************************************
    bsrs_rise_type rise_r;
    bsrs_rise_type rise_nxt;
    bsrs_fall_type fall_r;
    bsrs_fall_type fall_nxt;
    bsrs_decode_type dec;
    logic [BSR_WIDTH-1:0] capCells;
    logic tdiS;

    assign tdiS = rise_r.tdiSync[1];
    assign dec = bsrs_decode(fall_r.irShadow); // [R1] [R2] [R6]

    always_comb begin
        // input cells from pins, output cells from core [R13] [R18] [R19]
        capCells = {pinSync2_r[9], pinSync2_r[8], pinSync2_r[7:0],
                    coreSync2_r};
        rise_nxt = rise_r;
        rise_nxt.tdiSync = {rise_r.tdiSync[0], tdi}; // [R23]
        if (tap.testReset) begin
            rise_nxt.irShift = IR_RESET_VALUE; // [R5]
            rise_nxt.bcrShift = BCR_RESET_VALUE; // [R15]
        end else if (tap.captureIr) begin
            rise_nxt.irShift = IR_CAPTURE_VALUE; // [R3]
        end else if (tap.shiftIr) begin
            rise_nxt.irShift = {tdiS, rise_r.irShift[IR_WIDTH-1:1]}; // [R24]
        end else if (tap.captureDr) begin
            unique case (dec.sel)
                BSRS_SEL_BYPASS: rise_nxt.bypass = 1'b0; // [R17] [R20]
                BSRS_SEL_CELLS: begin
                    unique case (dec.cap)
                        BSRS_CAP_PINS: rise_nxt.bsrShift = capCells; // [R14]
                        BSRS_CAP_INVERT: rise_nxt.bsrShift = ~rise_r.bsrShift;
                        default: rise_nxt.bsrShift = rise_r.bsrShift;
                    endcase
                end
                default: rise_nxt.bcrShift = rise_r.bcrShift; // [R16]
            endcase
        end else if (tap.shiftDr) begin
            unique case (dec.sel)
                BSRS_SEL_BYPASS: rise_nxt.bypass = tdiS;
                BSRS_SEL_CELLS: // [R11] [R12]
                    rise_nxt.bsrShift = {tdiS, rise_r.bsrShift[BSR_WIDTH-1:1]};
                default:
                    rise_nxt.bcrShift = {tdiS, rise_r.bcrShift[1]}; // [R24]
            endcase
        end
    end

    always_ff @(posedge tck) begin
        if (!rst_b) begin
            rise_r <= '{IR_RESET_VALUE, '0, BCR_RESET_VALUE, 1'b0, 2'h0};
        end else begin
            rise_r <= rise_nxt;
        end
    end

    // ************************************************************
    // falling edge: shadow update and tdo
    // ************************************************************
    always_comb begin
        fall_nxt = fall_r;
        if (tap.testReset) begin
            fall_nxt.irShadow = IR_RESET_VALUE; // [R5]
            fall_nxt.bcrShadow = BCR_RESET_VALUE; // [R15]
        end else if (tap.updateIr) begin
            fall_nxt.irShadow = rise_r.irShift; // [R4] [R21]
        end else if (tap.updateDr) begin
            unique case (dec.sel)
                BSRS_SEL_CELLS: fall_nxt.bsrShadow = rise_r.bsrShift; // [R21]
                BSRS_SEL_CTRL: fall_nxt.bcrShadow = rise_r.bcrShift;
                default: fall_nxt.bsrShadow = fall_r.bsrShadow;
            endcase
        end
        fall_nxt.tdoEn = tap.shiftIr | tap.shiftDr;
        if (tap.shiftIr) begin
            fall_nxt.tdo = rise_r.irShift[0]; // [R23]
        end else begin
            unique case (dec.sel)
                BSRS_SEL_CELLS: fall_nxt.tdo = rise_r.bsrShift[0]; // [R12]
                BSRS_SEL_CTRL: fall_nxt.tdo = rise_r.bcrShift[0];
                default: fall_nxt.tdo = rise_r.bypass;
            endcase
        end
    end

    always_ff @(negedge tck) begin
        if (!rst_b) begin
            fall_r <= '{IR_RESET_VALUE, '0, BCR_RESET_VALUE, 1'b0, 1'b0};
        end else begin
            fall_r <= fall_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign testModeRaw = dec.mode != BSRS_MODE_NORMAL; // [R7] [R8] [R10]
    assign tdo = fall_r.tdo;
    assign tdoEn = fall_r.tdoEn;
    assign testMode = testModeClk_r;
    assign floatOutputs = dec.mode == BSRS_MODE_FLOAT; // [R9]
    assign cellDrive = fall_r.bsrShadow; // [R18]
    assign runOp = bsrs_runop_type'(fall_r.bcrShadow); // [R22]
    assign instruction = fall_r.irShadow;

    // ************************************************************
    // assertions
    // ************************************************************
    property p_ir_capture;
        @(posedge tck) disable iff (!rst_b)
        tap.captureIr && !tap.testReset |=> rise_r.irShift == 8'h81;
    endproperty
    a_ir_capture: assert property (p_ir_capture) // [R3]
        else $error("ir capture value wrong");

    property p_ir_reset;
        @(negedge tck) disable iff (!rst_b)
        tap.testReset |=> fall_r.irShadow == 8'hFF && runOp == 2'h2;
    endproperty
    a_ir_reset: assert property (p_ir_reset) // [R5]
        else $error("reset values wrong");

    property p_bypass_zero;
        @(posedge tck) disable iff (!rst_b)
        tap.captureDr && !tap.testReset && dec.sel == BSRS_SEL_BYPASS
        |=> !rise_r.bypass;
    endproperty
    a_bypass_zero: assert property (p_bypass_zero) // [R17]
        else $error("bypass did not capture zero");

    property p_ir_update;
        @(negedge tck) disable iff (!rst_b)
        tap.updateIr && !tap.testReset
        |=> fall_r.irShadow == $past(rise_r.irShift);
    endproperty
    a_ir_update: assert property (p_ir_update) // [R4]
        else $error("instruction not updated");

    property p_bit7_ignored;
        @(negedge tck) disable iff (!rst_b)
        dec == bsrs_decode({~fall_r.irShadow[7], fall_r.irShadow[6:0]});
    endproperty
    a_bit7_ignored: assert property (p_bit7_ignored) // [R1]
        else $error("bit 7 changed decode");

    property p_sample_normal;
        @(negedge tck) disable iff (!rst_b)
        fall_r.irShadow[6:0] == 7'h02 |-> !testModeRaw
            && dec.sel == BSRS_SEL_CELLS;
    endproperty
    a_sample_normal: assert property (p_sample_normal) // [R19]
        else $error("sample decode wrong");

    property p_ctrl_hold;
        @(posedge tck) disable iff (!rst_b)
        tap.captureDr && !tap.testReset && dec.sel == BSRS_SEL_CTRL
        |=> $stable(rise_r.bcrShift);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) // [R16]
        else $error("control register changed in capture");

    property p_chain_reset_hold;
        @(posedge tck) disable iff (!rst_b)
        tap.testReset |=> $stable(rise_r.bsrShift);
    endproperty
    a_chain_reset_hold: assert property (p_chain_reset_hold) // [R14]
        else $error("chain changed in reset");

    property p_tdo_ir;
        @(negedge tck) disable iff (!rst_b)
        tap.shiftIr |=> tdoEn && tdo == $past(rise_r.irShift[0]);
    endproperty
    a_tdo_ir: assert property (p_tdo_ir) // [R23]
        else $error("tdo wrong in ir shift");

endmodule

`default_nettype wire

// ---- tb/bsrs_tap_master.sv ----
// partner: test bus controller driving tap strobes and serial data
// assumes: dut samples strobes on rising tck, drives tdo on falling tck
`timescale 1ns/1ps
`default_nettype none

module bsrs_tap_master
    import bsrs_pkg::*;
(
    output var logic tck,
    output var logic tdi,
    output var bsrs_tap_type tap,
    input wire logic tdo
);
    // ****************
    // idle state
    // ****************
    initial begin
        tck = 1'b0;
        tdi = 1'b1;
        tap = '0;
    end
    always #7.5 tck = ~tck;

    // ****************
    // scans
    // ****************
    // tdi leads each shift strobe by two slots
    task automatic scan(input logic ir, input int n, input logic upd,
            input logic [19:0] din, output logic [19:0] dout);
        dout = '0;
        @(posedge tck) tdi <= din[0];
        @(posedge tck) begin
            tap <= bsrs_tap_type'(ir ? 7'h20 : 7'h04);
            tdi <= din[1];
        end
        for (int i = 0; i < n; i++) begin
            @(posedge tck) begin
                if (i > 0) dout[i-1] = tdo;
                tap <= bsrs_tap_type'(ir ? 7'h10 : 7'h02);
                tdi <= (i + 2 < 20) ? din[i+2] : 1'b1;
            end
        end
        @(posedge tck) begin
            dout[n-1] = tdo;
            tap <= bsrs_tap_type'(upd ? (ir ? 7'h08 : 7'h01) : 7'h00);
            tdi <= 1'b1;
        end
        @(posedge tck) tap <= '0;
    endtask

    task automatic pulse_reset();
        @(posedge tck) tap <= bsrs_tap_type'(7'h40);
        @(posedge tck) tap <= '0;
        @(posedge tck);
    endtask
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
// testbench: scans instructions and data through the register set
// assumes: partner model makes tck; bench makes clk and drives pins
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import bsrs_pkg::*;
;
    logic clk, rst_b, tck, tdi, tdo, tdoEn, testMode, floatOutputs;
    bsrs_tap_type tap;
    bsrs_pins_type pinsIn;
    logic [7:0] coreOut, instruction;
    logic [BSR_WIDTH-1:0] cellDrive;
    bsrs_runop_type runOp;
    int failures, compares, cycles;
    logic [19:0] din, dout, last;
    logic [6:0] op, want;
    logic [1:0] prev;

    bsrs_tap_master m (.tck(tck), .tdi(tdi), .tap(tap), .tdo(tdo));

    bsrs_register_set #(.CELLS(BSR_WIDTH)) dut (
        .clk(clk), .rst_b(rst_b), .tck(tck), .tdi(tdi), .tap(tap),
        .pinsIn(pinsIn), .coreOut(coreOut), .tdo(tdo), .tdoEn(tdoEn),
        .testMode(testMode), .floatOutputs(floatOutputs),
        .cellDrive(cellDrive), .runOp(runOp), .instruction(instruction)
    );

    // ****************
    // helpers
    // ****************
    always #10 clk = ~clk;

    task automatic check(input string name, input logic [19:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // {test mode, float, selected length}
    function automatic logic [6:0] expect_of(input logic [6:0] o);
        case (o)
            7'h00, 7'h03, 7'h0B: return 7'h52;
            7'h02, 7'h0A, 7'h0C: return 7'h12;
            7'h06: return 7'h61;
            7'h07, 7'h09, 7'h0D: return 7'h41;
            7'h0E: return 7'h02;
            7'h0F: return 7'h42;
            default: return 7'h01;
        endcase
    endfunction

    task automatic ir(input logic [7:0] v);
        m.scan(1'b1, 8, 1'b1, {12'hFFF, v}, dout);
        check("capture", dout[7:0], 8'h81);
        check("instr", instruction, v);
        repeat (4) @(posedge clk);
    endtask

    task automatic new_pins();
        @(posedge clk);
        pinsIn <= bsrs_pins_type'(10'($urandom));
        coreOut <= 8'($urandom);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            stop_test();
        end
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        pinsIn = '0;
        coreOut = '0;
        void'($urandom(97029));
        repeat (10) @(posedge clk);
        check("instr", instruction, 8'hFF);
        check("runop", runOp, 2'h2);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 22; k++) begin
            op = (k < 16) ? 7'(k) : 7'($urandom_range(127, 16));
            ir({1'($urandom), op});
            want = expect_of(op);
            check("mode", testMode, want[6]);
            check("float", floatOutputs, want[5]);
            din = 20'($urandom);
            m.scan(1'b0, 20, 1'b0, din, dout);
            check("path", dout[want[4:0] +: 2], din[1:0]);
            if (want[4:0] == 5'h01) check("bypass", dout[0], 1'b0);
        end
        m.pulse_reset();
        check("runop", runOp, 2'h2);
        ir(8'h0E);
        prev = 2'h2;
        for (int v = 0; v < 4; v++) begin
            m.scan(1'b0, 2, 1'b1, 20'(v), dout);
            check("ctrl", dout[1:0], prev);
            check("runop", runOp, v);
            prev = 2'(v);
        end
        new_pins();
        ir(8'h80);
        din = 20'($urandom);
        m.scan(1'b0, 18, 1'b1, din, dout);
        check("cells", dout[17:0], {pinsIn, coreOut});
        check("drive", cellDrive, din[17:0]);
        new_pins();
        ir(8'h82);
        last = 20'($urandom);
        m.scan(1'b0, 18, 1'b0, last, dout);
        check("sample", dout[17:0], {pinsIn, coreOut});
        m.pulse_reset();
        check("instr", instruction, 8'hFF);
        check("runop", runOp, 2'h2);
        ir(8'h0A);
        m.scan(1'b0, 18, 1'b0, 20'h0, dout);
        check("kept", dout[17:0], last[17:0]);
        stop_test();
    end
endmodule

`default_nettype wire
